// *** bench/ldpm_analog_model.sv ***
// Behavioural comparators that watch the input supply and the skip sense line
`timescale 1ns/1ps
module ldpm_analog_model (
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] skip_mv,
  input wire logic ov_level_sel,
  input wire logic skip_ref_sel,
  output logic vin_above_on_cmp,
  output logic vin_above_off_cmp,
  output logic ov_stop_cmp,
  output logic ov_release_cmp,
  output logic ov_latch_cmp,
  output logic skip_cmp
);
  wire logic [15:0] stop_mv;
  wire logic [15:0] latch_mv;
  wire logic [15:0] ref_mv;
  // Reference pairs follow the mode: 32V/33.5V or 45V/48V, skip at 1.4V or 1.0V
  assign stop_mv = ov_level_sel ? 16'hAFC8 : 16'h7D00;
  assign latch_mv = ov_level_sel ? 16'hBB80 : 16'h82DC;
  assign ref_mv = skip_ref_sel ? 16'h03E8 : 16'h0578;
  // Lockout pair: the off level sits 800mV under the 5.5V on level, so no chatter between them
  assign vin_above_on_cmp = vin_mv > 16'h157C;
  assign vin_above_off_cmp = vin_mv > 16'h125C;
  // Release stays high until the input is 1% under the stop level
  assign ov_stop_cmp = vin_mv > stop_mv;
  assign ov_release_cmp = 32'(vin_mv) * 32'h64 > 32'(stop_mv) * 32'h63;
  assign ov_latch_cmp = vin_mv > latch_mv;
  assign skip_cmp = skip_mv > ref_mv;
endmodule

// *** bench/ldpm_ctrl_tb_top.sv ***
// Self-checking bench for the LED protection and mode controller
`timescale 1ns/1ps
module ldpm_ctrl_tb_top;
  import ldpm_pkg::*;
  localparam int G = 5, BK = 4, LN = 3, DC = 2, BL = 1, XC = 0;
  logic mclk, reset_n, vcc_ok_cmp, mode_strap_sense, skip_disable_strap, low_dim_strap;
  logic low_dim_req, line_half, bleed_req, bleed_fault, headroom_low, avs_read, avs_write;
  logic hf_edge_in, hf_run;
  logic [1:0] hf_cnt;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] vin_mv, skip_mv;
  logic [7:0] boost_trim;
  wire logic on_c, off_c, stop_c, rel_c, lat_c, skp_c, lvl_sel, ref_sel;
  logic avs_waitrequest, main_gate_en, buck_en, linear_en, discontinuous_conduction, bleed_on, xcap;
  wire logic [5:0] outs;
  int err_total, cmp_count;
  assign outs = {main_gate_en, buck_en, linear_en, discontinuous_conduction, bleed_on, xcap};

  // Shortened counts keep the run short; the linear bleeder cap keeps its real length
  ldpm_ctrl #(.OV_CYC(200), .BLD_BB_CYC(60), .ET_WIN_CYC(100), .START_CYC(50), .TRIM_CYC(10))
    i_ldpm_ctrl (.mclk(mclk), .reset_n(reset_n), .vcc_ok_cmp(vcc_ok_cmp), .vin_above_on_cmp(on_c),
    .vin_above_off_cmp(off_c), .ov_stop_cmp(stop_c), .ov_release_cmp(rel_c), .ov_latch_cmp(lat_c),
    .mode_strap_sense(mode_strap_sense), .skip_disable_strap(skip_disable_strap), .low_dim_strap(low_dim_strap),
    .hf_edge_in(hf_edge_in), .skip_cmp(skp_c), .low_dim_req(low_dim_req), .line_half(line_half),
    .bleed_req(bleed_req), .bleed_fault(bleed_fault), .headroom_low(headroom_low), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .main_gate_en(main_gate_en), .buck_en(buck_en), .linear_en(linear_en),
    .discontinuous_conduction(discontinuous_conduction), .ov_level_sel(lvl_sel), .skip_ref_sel(ref_sel),
    .bleed_on(bleed_on), .extra_cap_switch_out(xcap), .boost_trim(boost_trim));
  ldpm_analog_model i_ldpm_analog_model (.vin_mv(vin_mv), .skip_mv(skip_mv), .ov_level_sel(lvl_sel),
    .skip_ref_sel(ref_sel), .vin_above_on_cmp(on_c), .vin_above_off_cmp(off_c), .ov_stop_cmp(stop_c),
    .ov_release_cmp(rel_c), .ov_latch_cmp(lat_c), .skip_cmp(skp_c));

  always #10 mclk = ~mclk;
  // Transformer ripple: one rising edge every four cycles, well inside the detector's reach
  always @(posedge mclk) begin
    hf_cnt <= hf_run ? hf_cnt + 2'h1 : 2'h0;
    hf_edge_in <= hf_cnt[1];
  end

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A wait that runs out is counted and ends the run
  task automatic bail();
    chk(32'h0, 32'h1);
    wrap_up();
  endtask
  // One Avalon access; held until waitrequest is sampled low at a rising edge, data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) bail();
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Wait for an output to reach a level, or with stay set, check that it holds for lim cycles
  task automatic wt(input int b, input logic v, input int lim, input bit stay);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      if ((outs[b] === v) != stay) break;
    end
    if (!stay && n == lim) bail();
    chk(32'(outs[b]), 32'(v));
  endtask
  task automatic step(input logic [15:0] v_in, input logic [15:0] sk, input logic v, input int lim, input bit st);
    vin_mv <= v_in;
    skip_mv <= sk;
    wt(G, v, lim, st);
  endtask
  // Reset, strap the pins, raise the internal supply and wait for the run state
  task automatic start(input logic m, input logic sd, input logic ld, input logic f);
    int n;
    @(posedge mclk);
    reset_n <= 1'b0;
    vcc_ok_cmp <= 1'b0;
    {low_dim_req, line_half, bleed_req, headroom_low} <= 4'h0;
    vin_mv <= 16'h2EE0;
    skip_mv <= 16'h0000;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    {mode_strap_sense, skip_disable_strap, low_dim_strap} <= {m, sd, ld};
    wt(G, 1'b0, 20, 1'b1);
    rdc(REG_STATUS, 32'h3, 32'h0);
    vcc_ok_cmp <= 1'b1;
    bleed_fault <= f;
    hf_run <= 1'b1;
    for (n = 0; n < 40; n++) begin
      bus(1'b0, REG_STATUS, 32'h0, q);
      if (q[1:0] === 2'h2) break;
    end
    if (n == 40) bail();
    bleed_fault <= 1'b0;
    chk(32'(q[2]), 32'(m));
  endtask
  // Bleeder conducts only in the eligible half cycle and for at most cap cycles
  task automatic bleed(input int cap);
    int n;
    line_half <= 1'b1;
    bleed_req <= 1'b1;
    wt(BL, 1'b1, 10, 1'b0);
    for (n = 0; n < cap + 20 && outs[BL] === 1'b1; n++) @(posedge mclk);
    chk(32'(n <= cap && n + 5 > cap), 32'h1);
    line_half <= 1'b0;
    wt(BL, 1'b0, 20, 1'b1);
    bleed_req <= 1'b0;
  endtask

  initial begin
    {mclk, reset_n, vcc_ok_cmp, mode_strap_sense, skip_disable_strap, low_dim_strap} = 6'h00;
    {low_dim_req, line_half, bleed_req, bleed_fault, headroom_low, avs_read, avs_write} = 7'h00;
    {hf_edge_in, hf_run, hf_cnt, avs_address, avs_writedata} = 40'h0;
    vin_mv = 16'h2EE0;
    skip_mv = 16'h0000;
    err_total = 0;
    cmp_count = 0;
    // Boost-buck, skip allowed, low-dim strap high
    start(1'b1, 1'b1, 1'b1, 1'b0);
    wt(G, 1'b1, 20, 1'b0);
    chk(32'({lvl_sel, ref_sel, outs[BK], outs[LN], outs[XC]}), 32'h04);
    low_dim_req <= 1'b1;
    wt(DC, 1'b0, 20, 1'b1);
    low_dim_req <= 1'b0;
    step(16'h1388, 16'h0000, 1'b1, 20, 1'b1);
    step(16'h0FA0, 16'h0000, 1'b0, 20, 1'b0);
    step(16'h1388, 16'h0000, 1'b0, 20, 1'b1);
    step(16'h1770, 16'h0000, 1'b1, 20, 1'b0);
    step(16'h7EF4, 16'h0000, 1'b0, 20, 1'b0);
    step(16'h7C38, 16'h0000, 1'b0, 20, 1'b1);
    step(16'h7918, 16'h0000, 1'b1, 20, 1'b0);
    // Sticky overvoltage flag survives the release and clears on a write of one
    rdc(REG_STATUS, 32'h100, 32'h100);
    bus(1'b1, REG_STATUS, 32'h100, q);
    rdc(REG_STATUS, 32'h100, 32'h0);
    step(16'h2EE0, 16'h05DC, 1'b0, 20, 1'b0);
    step(16'h2EE0, 16'h0514, 1'b1, 20, 1'b0);
    bus(1'b1, REG_CTRL, 32'h2, q);
    wt(G, 1'b0, 10, 1'b0);
    rdc(REG_CTRL, 32'h3, 32'h2);
    bus(1'b1, REG_CTRL, 32'h0, q);
    wt(G, 1'b1, 10, 1'b0);
    rdc(4'hC, 32'hFFFFFFFF, 32'h0);
    hf_run <= 1'b0;
    wt(XC, 1'b1, 300, 1'b0);
    hf_run <= 1'b1;
    wt(XC, 1'b0, 300, 1'b0);
    bleed(60);
    // Overvoltage held past the shortened timeout latches the block off
    step(16'h7EF4, 16'h0000, 1'b0, 20, 1'b0);
    wt(G, 1'b0, 250, 1'b1);
    step(16'h2EE0, 16'h0000, 1'b0, 30, 1'b1);
    rdc(REG_STATUS, 32'h3, 32'h3);
    // Boost-buck with the low-dim strap grounded
    start(1'b1, 1'b1, 1'b0, 1'b0);
    low_dim_req <= 1'b1;
    wt(DC, 1'b1, 20, 1'b0);
    // Boost-linear with skip disabled
    start(1'b0, 1'b0, 1'b1, 1'b0);
    chk(32'({lvl_sel, ref_sel, outs[BK], outs[LN]}), 32'hD);
    step(16'h2EE0, 16'h044C, 1'b1, 20, 1'b1);
    step(16'hB3B0, 16'h0000, 1'b0, 20, 1'b0);
    step(16'h2EE0, 16'h0000, 1'b1, 20, 1'b0);
    headroom_low <= 1'b1;
    repeat (100) @(posedge mclk);
    chk(32'(boost_trim > 8'h05), 32'h1);
    headroom_low <= 1'b0;
    repeat (300) @(posedge mclk);
    chk(32'(boost_trim), 32'h0);
    bleed(BLEED_LIN_CYC);
    step(16'hBD74, 16'h0000, 1'b0, 20, 1'b0);
    step(16'h2EE0, 16'h0000, 1'b0, 20, 1'b1);
    rdc(REG_STATUS, 32'h3, 32'h3);
    // Boost-linear with skip allowed
    start(1'b0, 1'b1, 1'b1, 1'b0);
    step(16'h2EE0, 16'h044C, 1'b0, 20, 1'b0);
    step(16'h2EE0, 16'h0384, 1'b1, 20, 1'b0);
    // Internal supply lost while running drops back to off
    vcc_ok_cmp <= 1'b0;
    wt(G, 1'b0, 20, 1'b0);
    rdc(REG_STATUS, 32'h3, 32'h0);
    // Bleeder fault while starting keeps the boost off
    start(1'b1, 1'b1, 1'b1, 1'b1);
    wt(G, 1'b0, 30, 1'b1);
    rdc(REG_STATUS, 32'h20, 32'h20);
    wrap_up();
  end
endmodule

// *** src/ldpm_ctrl.sv ***
// Protection, mode selection, transformer detection, bleeder and skip control with Avalon-MM registers
`timescale 1ns/1ps
module ldpm_ctrl #(
  parameter int OV_CYC = ldpm_pkg::OV_TIMEOUT_CYC,
  parameter int BLD_BB_CYC = ldpm_pkg::BLEED_BB_CYC,
  parameter int BLD_LIN_CYC = ldpm_pkg::BLEED_LIN_CYC,
  parameter int ET_WIN_CYC = ldpm_pkg::ET_WINDOW_CYC,
  parameter int START_CYC = ldpm_pkg::STARTUP_CYC,
  parameter int TRIM_CYC = ldpm_pkg::TRIM_TICK_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic vcc_ok_cmp,
  input wire logic vin_above_on_cmp,
  input wire logic vin_above_off_cmp,
  input wire logic ov_stop_cmp,
  input wire logic ov_release_cmp,
  input wire logic ov_latch_cmp,
  input wire logic mode_strap_sense,
  input wire logic skip_disable_strap,
  input wire logic low_dim_strap,
  input wire logic hf_edge_in,
  input wire logic skip_cmp,
  input wire logic low_dim_req,
  input wire logic line_half,
  input wire logic bleed_req,
  input wire logic bleed_fault,
  input wire logic headroom_low,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic main_gate_en,
  output logic buck_en,
  output logic linear_en,
  output logic discontinuous_conduction,
  output logic ov_level_sel,
  output logic skip_ref_sel,
  output logic bleed_on,
  output logic extra_cap_switch_out,
  output logic [7:0] boost_trim
);
  import ldpm_pkg::*;

  localparam int OVW = $clog2(OV_CYC + 1);
  localparam int BLW = $clog2(BLD_BB_CYC + BLD_LIN_CYC + 1);
  localparam int ETW = $clog2(ET_WIN_CYC + 1);
  localparam int SUW = $clog2(START_CYC + 1);
  localparam int TRW = $clog2(TRIM_CYC + 1);

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  ldpm_state_t state_q, state_d;
  logic undervoltage_lockout_ok_q, ov_stop_q, hf_prev_q, line_prev_q, magnetic_q, edge_seen_q, boost_fault_q;
  logic mode_bb_q, skipdis_lo_q, lowdim_hi_q, ov_seen_q, bleed_q;
  logic [1:0] ctrl_q;
  logic [7:0] trim_q;
  logic [OVW-1:0] ov_cnt_q;
  logic [BLW-1:0] bld_cnt_q;
  logic [ETW-1:0] et_cnt_q;
  logic [SUW-1:0] su_cnt_q;
  logic [TRW-1:0] tr_cnt_q;
  logic ack_q;
  logic [31:0] rdata_q;

  // Every comparator and strap passes two flops before use
  assign raw_in = {headroom_low, bleed_fault, bleed_req, line_half, low_dim_req, skip_cmp, hf_edge_in,
                   low_dim_strap, skip_disable_strap, mode_strap_sense, ov_latch_cmp, ov_release_cmp,
                   ov_stop_cmp, vin_above_off_cmp, vin_above_on_cmp, vcc_ok_cmp};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        s1_q[gi] <= reset_n ? raw_in[gi] : 1'b0;
        s2_q[gi] <= reset_n ? s1_q[gi] : 1'b0;
      end
    end
  endgenerate

  // Decoded conditions
  wire vcc_ok = s2_q[S_VCC];
  wire running = (state_q == ST_RUN);
  wire latch_trip = running && (s2_q[S_OVL] || ov_cnt_q == OVW'(OV_CYC));
  wire start_done = (su_cnt_q == SUW'(START_CYC));
  wire skip_allowed = !ctrl_q[CTRL_SKIP_OFF] && !(!mode_bb_q && skipdis_lo_q);
  wire skip_hold = skip_allowed && s2_q[S_SKIP];
  wire [BLW-1:0] bld_cap = mode_bb_q ? BLW'(BLD_BB_CYC) : BLW'(BLD_LIN_CYC);
  wire hf_edge = s2_q[S_HF] && !hf_prev_q;
  wire line_edge = s2_q[S_LINE] != line_prev_q;
  wire et_win_end = (et_cnt_q == ETW'(ET_WIN_CYC));
  wire trim_tick = (tr_cnt_q == TRW'(TRIM_CYC));
  wire acc = (avs_read || avs_write) && !ack_q;
  // Writes commit on the edge where waitrequest is low, so a master that aborts early changes nothing
  wire wr_ctrl = ack_q && avs_write && avs_address == REG_CTRL;
  wire wr_stat = ack_q && avs_write && avs_address == REG_STATUS;

  // Power state: latch holds until the supply reset, since only power cycling clears it
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (vcc_ok) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (!vcc_ok) begin
          state_d = ST_OFF;
        end else if (start_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (latch_trip) begin
          state_d = ST_LATCH;
        end else if (!vcc_ok) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_LATCH;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Straps are caught once at enable so a moving pin cannot flip the mode mid-run
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_bb_q <= 1'b0;
      skipdis_lo_q <= 1'b0;
      lowdim_hi_q <= 1'b0;
    end else if (state_q == ST_OFF && vcc_ok) begin
      mode_bb_q <= s2_q[S_MODE];
      skipdis_lo_q <= !s2_q[S_SKIPDIS];
      lowdim_hi_q <= s2_q[S_LOWDIM];
    end
  end

  // Input lockout with hysteresis between the on and off comparators
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      undervoltage_lockout_ok_q <= 1'b0;
    end else if (s2_q[S_UV_ON]) begin
      undervoltage_lockout_ok_q <= 1'b1;
    end else if (!s2_q[S_UV_OFF]) begin
      undervoltage_lockout_ok_q <= 1'b0;
    end
  end

  // Overvoltage stop and its duration counter
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ov_stop_q <= 1'b0;
      ov_cnt_q <= '0;
    end else begin
      if (s2_q[S_OVP]) begin
        ov_stop_q <= 1'b1;
      end else if (!s2_q[S_OVP_REL]) begin
        ov_stop_q <= 1'b0;
      end
      ov_cnt_q <= (ov_stop_q && running && ov_cnt_q != OVW'(OV_CYC)) ? ov_cnt_q + 1'b1 : '0;
    end
  end

  // Start-up timer and bleeder fault latch during it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      su_cnt_q <= '0;
      boost_fault_q <= 1'b0;
    end else begin
      su_cnt_q <= (state_q == ST_START && !start_done) ? su_cnt_q + 1'b1 : (state_q == ST_START ? su_cnt_q : '0);
      if (state_q == ST_START && s2_q[S_BLDFLT]) begin
        boost_fault_q <= 1'b1;
      end
    end
  end

  // Transformer detection: a window with no rising HF edge means magnetic; a window with a rising edge returns to electronic
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      magnetic_q <= 1'b0;
      edge_seen_q <= 1'b0;
      et_cnt_q <= '0;
      hf_prev_q <= 1'b0;
    end else begin
      hf_prev_q <= s2_q[S_HF];
      if (!running) begin
        et_cnt_q <= '0;
        edge_seen_q <= 1'b0;
      end else if (et_win_end) begin
        magnetic_q <= !(edge_seen_q || hf_edge);
        edge_seen_q <= 1'b0;
        et_cnt_q <= '0;
      end else begin
        edge_seen_q <= edge_seen_q || hf_edge;
        et_cnt_q <= et_cnt_q + 1'b1;
      end
    end
  end

  // Bleeder on-time, restarted at each half-cycle change and capped per mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bleed_q <= 1'b0;
      bld_cnt_q <= '0;
      line_prev_q <= 1'b0;
    end else begin
      line_prev_q <= s2_q[S_LINE];
      if (line_edge || !running) begin
        bld_cnt_q <= '0;
      end else if (bleed_q) begin
        bld_cnt_q <= bld_cnt_q + 1'b1;
      end
      bleed_q <= running && !line_edge && s2_q[S_LINE] && s2_q[S_BLDREQ] && (bld_cnt_q < bld_cap - 1'b1);
    end
  end

  // Linear headroom trim: step the boost target down unless the regulator runs short
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tr_cnt_q <= '0;
      trim_q <= TRIM_RESET;
    end else begin
      tr_cnt_q <= trim_tick ? '0 : tr_cnt_q + 1'b1;
      if (mode_bb_q || !running) begin
        trim_q <= TRIM_RESET;
      end else if (trim_tick && s2_q[S_HEAD] && trim_q != TRIM_MAX) begin
        trim_q <= trim_q + 1'b1;
      end else if (trim_tick && !s2_q[S_HEAD] && trim_q != TRIM_RESET) begin
        trim_q <= trim_q - 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      main_gate_en <= 1'b0;
      buck_en <= 1'b0;
      linear_en <= 1'b0;
      discontinuous_conduction <= 1'b0;
      extra_cap_switch_out <= 1'b0;
    end else begin
      main_gate_en <= running && undervoltage_lockout_ok_q && !ov_stop_q && !latch_trip && !boost_fault_q
                      && !skip_hold && !ctrl_q[CTRL_BOOST_OFF];
      buck_en <= running && mode_bb_q;
      linear_en <= running && !mode_bb_q;
      discontinuous_conduction <= running && mode_bb_q && !lowdim_hi_q && s2_q[S_LOWREQ];
      extra_cap_switch_out <= running && magnetic_q;
    end
  end

  assign ov_level_sel = !mode_bb_q;
  assign skip_ref_sel = !mode_bb_q;
  assign bleed_on = bleed_q;
  assign boost_trim = trim_q;

  // Avalon slave: one wait cycle, then data and acknowledge together
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  wire [31:0] status_word = {23'h000000, ov_seen_q, 1'b0, magnetic_q, boost_fault_q, ov_stop_q, undervoltage_lockout_ok_q,
                             mode_bb_q, state_q};
  wire [31:0] rd_mux = (avs_address == REG_CTRL) ? {30'h00000000, ctrl_q} :
                       (avs_address == REG_STATUS) ? status_word :
                       (avs_address == REG_TRIM) ? {24'h000000, trim_q} : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
      ov_seen_q <= 1'b0;
    end else begin
      ack_q <= acc;
      if (acc && avs_read) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata[1:0];
      end
      // A new overvoltage beats a clear in the same cycle
      if (ov_stop_q) begin
        ov_seen_q <= 1'b1;
      end else if (wr_stat && avs_writedata[ST_OV_SEEN]) begin
        ov_seen_q <= 1'b0;
      end
    end
  end

  sequence s_ov_long;
    ov_cnt_q == OVW'(OV_CYC) && running;
  endsequence

  a_undervoltage_lockout_gate_low: assert property (@(posedge mclk) disable iff (!reset_n)
    !undervoltage_lockout_ok_q |=> !main_gate_en) else $error("gate on during lockout");
  a_ovp_stop_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    ov_stop_q |=> !main_gate_en) else $error("gate on during overvoltage");
  a_ov_timeout_latch: assert property (@(posedge mclk) disable iff (!reset_n)
    s_ov_long |=> state_q == ST_LATCH ##1 state_q == ST_LATCH) else $error("no latch after timeout");
  a_latch_stays: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_LATCH |=> state_q == ST_LATCH && !main_gate_en) else $error("latch released");
  a_vcc_enable: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_OFF |=> !main_gate_en && !buck_en && !linear_en) else $error("active while off");
  a_mode_outputs: assert property (@(posedge mclk) disable iff (!reset_n)
    running && $stable(state_q) |=> buck_en == mode_bb_q && linear_en == !mode_bb_q) else $error("mode out");
  a_capsw_magnetic: assert property (@(posedge mclk) disable iff (!reset_n)
    !magnetic_q |=> !extra_cap_switch_out) else $error("cap switch high without magnetic");
  a_bleed_cap: assert property (@(posedge mclk) disable iff (!reset_n)
    bleed_q |-> bld_cnt_q < bld_cap) else $error("bleeder beyond cap");
  a_skip_boost_off: assert property (@(posedge mclk) disable iff (!reset_n)
    skip_hold |=> !main_gate_en) else $error("boost on during skip");
  a_startup_fault: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_START && s2_q[S_BLDFLT] |=> boost_fault_q ##1 !main_gate_en) else $error("fault ignored");
  a_skip_strap_lin: assert property (@(posedge mclk) disable iff (!reset_n)
    !mode_bb_q && skipdis_lo_q |-> !skip_hold) else $error("skip active with strap low");
  a_dcm_strap: assert property (@(posedge mclk) disable iff (!reset_n)
    lowdim_hi_q |=> !discontinuous_conduction) else $error("dcm with strap high");
endmodule

// *** src/ldpm_pkg.sv ***
// Constants, register map and state encoding for the LED protection and mode controller
package ldpm_pkg;
  // Clock rate
  localparam int CLK_KHZ = 50000;
  // Documented times in their own units
  localparam int OV_TIMEOUT_US = 50000;
  localparam int BLEED_BB_NS = 1120000;
  localparam int BLEED_LIN_NS = 450000;
  // Documented times round down to whole cycles
  localparam int OV_TIMEOUT_CYC = OV_TIMEOUT_US * (CLK_KHZ / 1000);
  localparam int BLEED_BB_CYC = (BLEED_BB_NS / 1000) * CLK_KHZ / 1000;
  localparam int BLEED_LIN_CYC = (BLEED_LIN_NS / 1000) * CLK_KHZ / 1000;
  // Detector, start-up and trim defaults (no figure given for these)
  localparam int ET_WINDOW_CYC = 1000000;
  localparam int STARTUP_CYC = 500000;
  localparam int TRIM_TICK_CYC = 5000;
  // Threshold figures in millivolts (overvoltage hysteresis in percent); the overvoltage and skip pairs are selected through the reference select outputs
  localparam int UNDERVOLTAGE_LOCKOUT_ON_MV = 5500;
  localparam int UNDERVOLTAGE_LOCKOUT_HYS_MV = 800;
  localparam int OVP_BB_MV = 32000;
  localparam int OVL_BB_MV = 33500;
  localparam int OVP_LIN_MV = 45000;
  localparam int OVL_LIN_MV = 48000;
  localparam int OVP_HYS_PCT = 1;
  localparam int STRAP_MV = 2000;
  localparam int SKIP_REF_BB_MV = 1400;
  localparam int SKIP_REF_LIN_MV = 1000;
  // Synchronised input vector positions
  localparam int NSYNC = 16;
  localparam int S_VCC = 0, S_UV_ON = 1, S_UV_OFF = 2, S_OVP = 3, S_OVP_REL = 4, S_OVL = 5;
  localparam int S_MODE = 6, S_SKIPDIS = 7, S_LOWDIM = 8, S_HF = 9, S_SKIP = 10, S_LOWREQ = 11;
  localparam int S_LINE = 12, S_BLDREQ = 13, S_BLDFLT = 14, S_HEAD = 15;
  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TRIM = 4'h8;
  // Control bits
  localparam int CTRL_SKIP_OFF = 0;
  localparam int CTRL_BOOST_OFF = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] TRIM_MAX = 8'hFF;
  // Sticky status bit cleared by writing one
  localparam int ST_OV_SEEN = 8;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_START = 2'b01,
    ST_RUN = 2'b10,
    ST_LATCH = 2'b11
  } ldpm_state_t;
endpackage
